// >>> rtl/ccr_ctrl.sv
`timescale 1ns/100ps
`include "ccr_map.svh"
// Operation
// - with the 2-3 GB bit set, accesses 80000000h-BFFFFFFFh are serialized.
// - with the 1-2 GB bit set, accesses 40000000h-7FFFFFFFh are serialized.
// - with map enable 1, all indices are open and I/O port 22h is trapped.
// - with map enable 0, only C1h-C3h, CDh-CFh, FEh and FFh are open.
// - in SMM, suspend requests are honoured only if suspend-in-SMM is 1.
// - in SMM, NMI is recognized only if the SMM NMI enable is 1.
// - suspending-SMI verification is allowed if lock is 0 or in SMM.
module ccr_ctrl #(
	parameter ccr_pkg::ccr_byte_t REG_INDEX = `CCR_REG_INDEX,
	parameter ccr_pkg::ccr_byte_t RESET_VAL = `CCR_RESET_VAL
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic cfgWrEn,
	input wire logic cfgRdEn,
	input wire ccr_pkg::ccr_byte_t cfgIndex,
	input wire ccr_pkg::ccr_byte_t cfgWrData,
	output logic [7:0] cfgRdData,
	output logic cfgAccessOk,
	input wire logic memValid,
	input wire ccr_pkg::ccr_addr_t memAddr,
	output logic serializeAccess,
	input wire logic ioValid,
	input wire ccr_pkg::ccr_port_t ioPort,
	output logic ioTrap,
	input wire logic smmActive,
	input wire logic suspendRequestN,
	output logic suspendAccept,
	input wire logic nmiReq,
	output logic nmiAccept,
	input wire logic smiVerifyReq,
	output logic smiVerifyOk,
	output logic [7:0] cfgValue
);
	import ccr_pkg::*;

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic inRange(ccr_addr_t a, ccr_addr_t lo,
		ccr_addr_t hi);
		return (a >= lo) && (a <= hi);
	endfunction : inRange

	function automatic logic indexOpen(ccr_byte_t idx, logic cfg_map_enable);
		logic open;
		open = cfg_map_enable;
		if ((idx >= `CCR_OPEN_A_LO) && (idx <= `CCR_OPEN_A_HI)) begin
			open = 1'b1;
		end
		if ((idx >= `CCR_OPEN_B_LO) && (idx <= `CCR_OPEN_B_HI)) begin
			open = 1'b1;
		end
		if ((idx == `CCR_OPEN_C) || (idx == `CCR_OPEN_D)) begin
			open = 1'b1;
		end
		return open;
	endfunction : indexOpen

	// ****************************************************************
	// state
	// ****************************************************************
	ccr_state_t st_r;
	ccr_state_t st_nxt;
	logic cfg_map_enable;
	logic ser12En;
	logic ser23En;
	logic suspSmmEn;
	logic nmiSmmEn;
	logic smmLock;
	logic idxOk;
	logic hitReg;

	assign cfg_map_enable = st_r.cfg[`CCR_MAP_EN_BIT];
	assign ser12En = st_r.cfg[`CCR_SER_1G2G_BIT];
	assign ser23En = st_r.cfg[`CCR_SER_2G3G_BIT];
	assign suspSmmEn = st_r.cfg[`CCR_SUSPEND_REQUEST_N_SMM_BIT];
	assign nmiSmmEn = st_r.cfg[`CCR_NMI_EN_BIT];
	assign smmLock = st_r.cfg[`CCR_SMM_LOCK_BIT];

	always_comb begin
		st_nxt = st_r;
		idxOk = indexOpen(cfgIndex, cfg_map_enable);
		hitReg = idxOk && (cfgIndex == REG_INDEX);
		st_nxt.accessOk = (cfgWrEn || cfgRdEn) && idxOk;
		if (cfgWrEn && hitReg) begin
			st_nxt.cfg = cfgWrData;
			// reserved bit kept at zero
			st_nxt.cfg[`CCR_RSVD_BIT] = 1'b0;
		end
		st_nxt.rdData = 8'h00;
		if (cfgRdEn && hitReg) begin
			st_nxt.rdData = st_r.cfg;
		end
		st_nxt.serialize = memValid && (
			(ser12En && inRange(memAddr, `CCR_SER_1G2G_LO,
				`CCR_SER_1G2G_HI)) ||
			(ser23En && inRange(memAddr, `CCR_SER_2G3G_LO,
				`CCR_SER_2G3G_HI)));
		st_nxt.ioTrap = ioValid && cfg_map_enable &&
			(ioPort == `CCR_TRAP_PORT);
		st_nxt.suspAccept = !suspendRequestN &&
			(!smmActive || suspSmmEn);
		st_nxt.nmiAccept = nmiReq && (!smmActive || nmiSmmEn);
		st_nxt.verifyOk = smiVerifyReq &&
			(!smmLock || smmActive);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
			st_r.cfg <= RESET_VAL;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign cfgRdData = st_r.rdData;
	assign cfgAccessOk = st_r.accessOk;
	assign serializeAccess = st_r.serialize;
	assign ioTrap = st_r.ioTrap;
	assign suspendAccept = st_r.suspAccept;
	assign nmiAccept = st_r.nmiAccept;
	assign smiVerifyOk = st_r.verifyOk;
	assign cfgValue = st_r.cfg;

	// ****************************************************************
	// checks
	// ****************************************************************
	property p_ser23;
		@(posedge clk) disable iff (!arst_n)
		ce && memValid && ser23En && memAddr >= `CCR_SER_2G3G_LO &&
			memAddr <= `CCR_SER_2G3G_HI |=> serializeAccess;
	endproperty
	a_ser23: assert property (p_ser23)
		else $error("2-3 GB access not serialized");

	property p_ser12;
		@(posedge clk) disable iff (!arst_n)
		ce && memValid && !ser23En && memAddr >= `CCR_SER_1G2G_LO &&
			memAddr <= `CCR_SER_1G2G_HI |=>
			serializeAccess == $past(ser12En);
	endproperty
	a_ser12: assert property (p_ser12)
		else $error("1-2 GB serialization wrong");

	property p_ser_idle;
		@(posedge clk) disable iff (!arst_n)
		ce && !memValid |=> !serializeAccess;
	endproperty
	a_ser_idle: assert property (p_ser_idle)
		else $error("serialization without an access");

	property p_trap;
		@(posedge clk) disable iff (!arst_n)
		ce && ioValid && ioPort == `CCR_TRAP_PORT |=>
			ioTrap == $past(cfg_map_enable);
	endproperty
	a_trap: assert property (p_trap)
		else $error("port 22h trap wrong");

	property p_map_open;
		@(posedge clk) disable iff (!arst_n)
		ce && (cfgRdEn || cfgWrEn) && cfg_map_enable |=> cfgAccessOk;
	endproperty
	a_map_open: assert property (p_map_open)
		else $error("index refused with map enabled");

	property p_block;
		@(posedge clk) disable iff (!arst_n)
		ce && (cfgRdEn || cfgWrEn) && !cfg_map_enable &&
			cfgIndex < `CCR_OPEN_A_LO |=> !cfgAccessOk &&
			cfgRdData == 8'h00;
	endproperty
	a_block: assert property (p_block)
		else $error("closed index was reachable");

	property p_open;
		@(posedge clk) disable iff (!arst_n)
		ce && (cfgWrEn || cfgRdEn) && cfgIndex >= `CCR_OPEN_B_LO &&
			cfgIndex <= `CCR_OPEN_B_HI |=> cfgAccessOk;
	endproperty
	a_open: assert property (p_open)
		else $error("open index refused");

	property p_suspend_request_n;
		@(posedge clk) disable iff (!arst_n)
		ce && smmActive && !suspendRequestN |=>
			suspendAccept == $past(suspSmmEn);
	endproperty
	a_suspend_request_n: assert property (p_suspend_request_n)
		else $error("suspend in SMM wrong");

	property p_nmi;
		@(posedge clk) disable iff (!arst_n)
		ce && smmActive && nmiReq |=> nmiAccept == $past(nmiSmmEn);
	endproperty
	a_nmi: assert property (p_nmi)
		else $error("NMI in SMM wrong");

	property p_verify;
		@(posedge clk) disable iff (!arst_n)
		ce && smiVerifyReq && smmLock && !smmActive |=> !smiVerifyOk;
	endproperty
	a_verify: assert property (p_verify)
		else $error("verification allowed under lock");

	property p_unlock;
		@(posedge clk) disable iff (!arst_n)
		ce && smiVerifyReq && !smmLock |=> smiVerifyOk;
	endproperty
	a_unlock: assert property (p_unlock)
		else $error("verification refused while unlocked");

	property p_rsvd;
		@(posedge clk) disable iff (!arst_n)
		ce && cfgWrEn && cfgIndex == REG_INDEX |=>
			!cfgValue[`CCR_RSVD_BIT];
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved bit read as one");

	c_map: cover property (@(posedge clk) disable iff (!arst_n)
		cfg_map_enable && ioTrap);
	c_ser: cover property (@(posedge clk) disable iff (!arst_n)
		serializeAccess);
	c_nmi: cover property (@(posedge clk) disable iff (!arst_n)
		smmActive && nmiAccept);
	c_ver: cover property (@(posedge clk) disable iff (!arst_n)
		smmLock && smiVerifyOk);
endmodule : ccr_ctrl

// >>> rtl/ccr_map.svh
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH
// ****************************************************************
// register index and reset value
// ****************************************************************
`define CCR_REG_INDEX 8'hC3
`define CCR_RESET_VAL 8'h00
// ****************************************************************
// field positions
// ****************************************************************
`define CCR_SMM_LOCK_BIT 0
`define CCR_NMI_EN_BIT 1
`define CCR_RSVD_BIT 2
`define CCR_SUSPEND_REQUEST_N_SMM_BIT 3
`define CCR_MAP_EN_BIT 4
`define CCR_SER_1G2G_BIT 5
`define CCR_SER_2G3G_BIT 6
// ****************************************************************
// address ranges and ports
// ****************************************************************
`define CCR_SER_1G2G_LO 32'h40000000
`define CCR_SER_1G2G_HI 32'h7FFFFFFF
`define CCR_SER_2G3G_LO 32'h80000000
`define CCR_SER_2G3G_HI 32'hBFFFFFFF
`define CCR_TRAP_PORT 16'h0022
`define CCR_OPEN_A_LO 8'hC1
`define CCR_OPEN_A_HI 8'hC3
`define CCR_OPEN_B_LO 8'hCD
`define CCR_OPEN_B_HI 8'hCF
`define CCR_OPEN_C 8'hFE
`define CCR_OPEN_D 8'hFF
`endif

// >>> rtl/ccr_pkg.sv
package ccr_pkg;
	typedef logic [7:0] ccr_byte_t;
	typedef logic [31:0] ccr_addr_t;
	typedef logic [15:0] ccr_port_t;
	typedef struct packed {
		ccr_byte_t cfg;
		ccr_byte_t rdData;
		logic accessOk;
		logic serialize;
		logic ioTrap;
		logic suspAccept;
		logic nmiAccept;
		logic verifyOk;
	} ccr_state_t;
endpackage : ccr_pkg

// >>> dv/testbench.sv
`timescale 1ns/100ps
module testbench;
	import ccr_pkg::*;
	logic clk, arst_n, ce, cfgWrEn, cfgRdEn, memValid, ioValid, smmActive;
	logic suspendRequestN, nmiReq, smiVerifyReq;
	ccr_byte_t cfgIndex, cfgWrData;
	ccr_addr_t memAddr;
	ccr_port_t ioPort;
	logic [7:0] cfgRdData, cfgValue;
	logic cfgAccessOk, serializeAccess, ioTrap, suspendAccept, nmiAccept;
	logic smiVerifyOk;
	int n_mismatch = 0;
	int tests_run = 0;
	ccr_ctrl u_dut (.clk(clk), .arst_n(arst_n), .ce(ce), .cfgWrEn(cfgWrEn),
		.cfgRdEn(cfgRdEn), .cfgIndex(cfgIndex), .cfgWrData(cfgWrData),
		.cfgRdData(cfgRdData), .cfgAccessOk(cfgAccessOk),
		.memValid(memValid), .memAddr(memAddr),
		.serializeAccess(serializeAccess), .ioValid(ioValid),
		.ioPort(ioPort), .ioTrap(ioTrap), .smmActive(smmActive),
		.suspendRequestN(suspendRequestN), .suspendAccept(suspendAccept),
		.nmiReq(nmiReq), .nmiAccept(nmiAccept),
		.smiVerifyReq(smiVerifyReq), .smiVerifyOk(smiVerifyOk),
		.cfgValue(cfgValue));
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input string n, input logic [7:0] e, s);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// ****************************************************************
	// one config access, outputs checked 1 ns after the edge that takes it
	// ****************************************************************
	task automatic op(input logic w, input ccr_byte_t idx, d);
		@(posedge clk);
		cfgWrEn <= w;
		cfgRdEn <= !w;
		cfgIndex <= idx;
		cfgWrData <= d;
		@(posedge clk);
		cfgWrEn <= 1'b0;
		cfgRdEn <= 1'b0;
		#1;
	endtask : op
	task automatic upd;
		@(posedge clk);
		#1;
	endtask : upd
	task automatic t_reg;
		op(1, 8'hC3, 8'hFB);
		chk("value", 8'hFB, cfgValue);
		op(0, 8'hC3, 8'h00);
		chk("rdData", 8'hFB, cfgRdData);
		chk("accessOk", 8'h01, cfgAccessOk);
	endtask : t_reg
	task automatic t_map;
		ccr_byte_t openIdx[5] = '{8'hC1, 8'hC2, 8'hCF, 8'hFE, 8'hFF};
		ccr_byte_t shutIdx[4] = '{8'hC4, 8'hCC, 8'hD0, 8'hFD};
		op(1, 8'hC3, 8'h00);
		op(0, 8'hC0, 8'h00);
		chk("blocked", 8'h00, cfgAccessOk);
		for (int i = 0; i < 5; i++) begin
			op(0, openIdx[i], 8'h00);
			chk("open list", 8'h01, cfgAccessOk);
		end
		for (int i = 0; i < 4; i++) begin
			op(0, shutIdx[i], 8'h00);
			chk("shut list", 8'h00, cfgAccessOk);
		end
		op(0, 8'hCD, 8'h00);
		chk("open CD", 8'h01, cfgAccessOk);
		chk("rd CD", 8'h00, cfgRdData);
		op(0, 8'hFE, 8'h00);
		chk("open FE", 8'h01, cfgAccessOk);
		@(posedge clk);
		ioValid <= 1'b1;
		ioPort <= 16'h0022;
		upd;
		chk("trap off", 8'h00, ioTrap);
		op(1, 8'hC3, 8'h10);
		upd;
		chk("trap on", 8'h01, ioTrap);
		op(0, 8'hC0, 8'h00);
		chk("map open", 8'h01, cfgAccessOk);
		@(posedge clk);
		ioPort <= 16'h0023;
		upd;
		chk("trap 23", 8'h00, ioTrap);
		@(posedge clk);
		ioValid <= 1'b0;
		ioPort <= 16'h0022;
		upd;
		chk("trap idle", 8'h00, ioTrap);
	endtask : t_map
	task automatic t_ser;
		ccr_addr_t a[4] = '{32'h3FFFFFFF, 32'h40000000, 32'h7FFFFFFF,
			32'h80000000};
		ccr_addr_t b[4] = '{32'h7FFFFFFF, 32'h80000000, 32'hBFFFFFFF,
			32'hC0000000};
		@(posedge clk);
		memValid <= 1'b1;
		op(1, 8'hC3, 8'h20);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			memAddr <= a[i];
			upd;
			chk("ser 1g", (i == 1 || i == 2), serializeAccess);
		end
		op(1, 8'hC3, 8'h40);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			memAddr <= b[i];
			upd;
			chk("ser 2g", (i == 1 || i == 2), serializeAccess);
		end
		@(posedge clk);
		memValid <= 1'b0;
		memAddr <= 32'h80000000;
		upd;
		chk("ser idle", 8'h00, serializeAccess);
	endtask : t_ser
	task automatic t_smm;
		@(posedge clk);
		suspendRequestN <= 1'b0;
		nmiReq <= 1'b1;
		smiVerifyReq <= 1'b1;
		op(1, 8'hC3, 8'h01);
		upd;
		chk("verify lock", 8'h00, smiVerifyOk);
		chk("suspend_request_n out", 8'h01, suspendAccept);
		chk("nmi out", 8'h01, nmiAccept);
		@(posedge clk);
		smmActive <= 1'b1;
		upd;
		chk("verify smm", 8'h01, smiVerifyOk);
		chk("suspend_request_n smm0", 8'h00, suspendAccept);
		chk("nmi smm0", 8'h00, nmiAccept);
		op(1, 8'hC3, 8'h0A);
		upd;
		chk("suspend_request_n smm1", 8'h01, suspendAccept);
		chk("nmi smm1", 8'h01, nmiAccept);
		@(posedge clk);
		smmActive <= 1'b0;
		upd;
		chk("verify free", 8'h01, smiVerifyOk);
		@(posedge clk);
		suspendRequestN <= 1'b1;
		nmiReq <= 1'b0;
		smiVerifyReq <= 1'b0;
		upd;
		chk("suspend_request_n idle", 8'h00, suspendAccept);
		chk("nmi idle", 8'h00, nmiAccept);
		chk("verify idle", 8'h00, smiVerifyOk);
	endtask : t_smm
	task automatic summarize;
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	initial begin
		#40000;
		n_mismatch++;
		summarize;
	end
	initial begin
		{arst_n, cfgWrEn, cfgRdEn, memValid, ioValid, smmActive} = '0;
		{nmiReq, smiVerifyReq, cfgIndex, cfgWrData, memAddr, ioPort} = '0;
		ce = 1'b1;
		suspendRequestN = 1'b1;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		t_reg;
		t_map;
		t_ser;
		t_smm;
		summarize;
	end
endmodule : testbench
